// ### verilog/msg_deframer.sv
// Device end: receives characters, hunts for sync, checks both checksums.
// Assumes the host end frames messages as below; the line is asynchronous to I_CLK.
//
// Notes on behaviour
// - Words travel low byte, then high byte
// - Bits within byte go LSB first
// - Header and data each carry own checksum
// - Header always present; data part optional
// - Acks and requests are header only
// - Every field unit is sixteen bits
// - Fractions sent as scaled integers, no float
// - Each fixed-point field has defined LSB weight
// - Header starts with bytes 255 then 129
// - Header checksum negates sum of four words
// - Third word counts data words; zero is header-only
// - Data checksum ends message, not counted
`timescale 1ns/1ps
module msg_deframer #(
  parameter int BIT_CYC = msg_frame_pkg::BIT_CYC_DEF
) (
  // Clock and reset
  input wire logic I_CLK,
  input wire logic I_ARST_N,
  // Serial link
  ser_link_if.device LNK,
  // Header fields, valid with O_MSG_VALID
  output logic [15:0] O_MSG_ID,
  output logic [15:0] O_COUNT,
  output logic [15:0] O_FLAGS,
  // Data words as they arrive
  output logic [15:0] O_WORD,
  output logic O_WORD_VALID,
  // Message outcome pulses
  output logic O_MSG_VALID,
  output logic O_HDR_ERR,
  output logic O_DATA_ERR
);
  import msg_frame_pkg::*;

  localparam logic [CNT_W-1:0] BIT_M1 = CNT_W'(BIT_CYC - 1);
  localparam logic [CNT_W-1:0] HALF_M1 = CNT_W'(BIT_CYC / 2 - 1);

  // ----------------------------------------------------------------
  // Line synchroniser
  // ----------------------------------------------------------------
  logic rx_m_q;
  logic rx_s_q;

  // Two stages; only the second one is looked at
  always_ff @(posedge I_CLK or negedge I_ARST_N) begin
    if (!I_ARST_N) begin
      rx_m_q <= LINE_IDLE;
      rx_s_q <= LINE_IDLE;
    end else begin
      rx_m_q <= LNK.h2d;
      rx_s_q <= rx_m_q;
    end
  end

  // ----------------------------------------------------------------
  // Character receiver
  // ----------------------------------------------------------------
  logic busy_q;
  logic [CNT_W-1:0] baud_q;
  logic [3:0] bit_q;
  logic [7:0] sh_q;
  logic byte_v_q;
  logic [7:0] byte_q;
  logic tick;
  logic start_seen;

  assign tick = busy_q && (baud_q == '0);
  assign start_seen = !busy_q && (rx_s_q == START_LVL);

  // Start bit is re-checked at mid bit so a glitch does not start a character
  always_ff @(posedge I_CLK or negedge I_ARST_N) begin
    if (!I_ARST_N) begin
      busy_q <= 1'b0;
      baud_q <= '0;
      bit_q <= 4'h0;
      sh_q <= 8'h00;
      byte_v_q <= 1'b0;
      byte_q <= 8'h00;
    end else begin
      byte_v_q <= 1'b0;
      if (start_seen) begin
        busy_q <= 1'b1;
        baud_q <= HALF_M1;
        bit_q <= 4'h0;
      end else if (tick) begin
        baud_q <= BIT_M1;
        if (bit_q == 4'h0) begin
          busy_q <= (rx_s_q == START_LVL);
          bit_q <= 4'h1;
        end else if (bit_q != STOP_IDX) begin
          sh_q <= {rx_s_q, sh_q[7:1]};
          bit_q <= bit_q + 4'h1;
        end else begin
          busy_q <= 1'b0;
          byte_v_q <= (rx_s_q == LINE_IDLE);
          byte_q <= sh_q;
        end
      end else if (busy_q) begin
        baud_q <= baud_q - 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------
  // Message framing
  // ----------------------------------------------------------------
  frame_st_t st_q;
  logic hunt_ff_q;
  logic half_q;
  logic [7:0] lo_q;
  logic [2:0] widx_q;
  logic [15:0] sum_q;
  logic [15:0] dsum_q;
  logic [15:0] rem_q;
  logic [15:0] wrd;
  logic wdone;
  logic hdr_ok;
  logic data_ok;
  logic sync_hit;

  // Word assembly and checksum compares
  assign wrd = {byte_q, lo_q};
  assign wdone = byte_v_q && half_q && (st_q != F_HUNT);
  assign hdr_ok = (wrd == chk_of(sum_q));
  assign data_ok = (wrd == chk_of(dsum_q));
  assign sync_hit = hunt_ff_q && (byte_q == SYNC_HI);

  // Header fields and data are passed on as integers; scaling is left to software
  always_ff @(posedge I_CLK or negedge I_ARST_N) begin
    if (!I_ARST_N) begin
      st_q <= F_HUNT;
      hunt_ff_q <= 1'b0;
      half_q <= 1'b0;
      lo_q <= 8'h00;
      widx_q <= 3'h0;
      sum_q <= 16'h0000;
      dsum_q <= 16'h0000;
      rem_q <= 16'h0000;
      O_MSG_ID <= 16'h0000;
      O_COUNT <= 16'h0000;
      O_FLAGS <= 16'h0000;
      O_WORD <= 16'h0000;
      O_WORD_VALID <= 1'b0;
      O_MSG_VALID <= 1'b0;
      O_HDR_ERR <= 1'b0;
      O_DATA_ERR <= 1'b0;
    end else begin
      O_WORD_VALID <= 1'b0;
      O_MSG_VALID <= 1'b0;
      O_HDR_ERR <= 1'b0;
      O_DATA_ERR <= 1'b0;
      if (byte_v_q && (st_q != F_HUNT)) begin
        half_q <= !half_q;
        lo_q <= byte_q;
      end
      case (st_q)
        F_HUNT: begin
          hunt_ff_q <= byte_v_q ? (byte_q == SYNC_LO) : hunt_ff_q;
          if (byte_v_q && sync_hit) begin
            st_q <= F_HDR;
            half_q <= 1'b0;
            widx_q <= 3'h1;
            sum_q <= SYNC_WORD;
          end
        end
        F_HDR: begin
          if (wdone) begin
            widx_q <= widx_q + 3'h1;
            sum_q <= sum_q + wrd;
            case (widx_q)
              W_ID[2:0]: O_MSG_ID <= wrd;
              W_CNT[2:0]: O_COUNT <= wrd;
              W_FLG[2:0]: O_FLAGS <= wrd;
              default: begin
                hunt_ff_q <= 1'b0;
                if (!hdr_ok) begin
                  O_HDR_ERR <= 1'b1;
                  st_q <= F_HUNT;
                end else if (O_COUNT == 16'h0000) begin
                  O_MSG_VALID <= 1'b1;
                  st_q <= F_HUNT;
                end else begin
                  st_q <= F_DATA;
                  rem_q <= O_COUNT;
                  dsum_q <= 16'h0000;
                end
              end
            endcase
          end
        end
        F_DATA: begin
          if (wdone && (rem_q != 16'h0000)) begin
            O_WORD <= wrd;
            O_WORD_VALID <= 1'b1;
            dsum_q <= dsum_q + wrd;
            rem_q <= rem_q - 16'h0001;
          end else if (wdone) begin
            // Final word is the data checksum, outside the count
            O_MSG_VALID <= data_ok;
            O_DATA_ERR <= !data_ok;
            hunt_ff_q <= 1'b0;
            st_q <= F_HUNT;
          end
        end
        default: begin
          st_q <= F_HUNT;
        end
      endcase
    end
  end

  // concern field meaning only: words pass through unscaled.
endmodule

// ### verilog/msg_frame_pkg.sv
// Shared constants, state types and the checksum function of the message link.
// Assumes both ends are built from this package and run from one 40 MHz clock.
package msg_frame_pkg;

  // ----------------------------------------------------------------
  // Clock and character timing
  // ----------------------------------------------------------------
  localparam int CLK_HZ = 40_000_000;
  localparam int BAUD_DEF = 9600;
  localparam int BIT_CYC_DEF = CLK_HZ / BAUD_DEF;
  localparam int CNT_W = 16;
  localparam int DATA_BITS = 8;
  localparam logic [3:0] CHAR_BITS = 4'h9;
  localparam logic [3:0] STOP_IDX = 4'h9;
  localparam logic LINE_IDLE = 1'b1;
  localparam logic START_LVL = 1'b0;

  // ----------------------------------------------------------------
  // Message layout
  // ----------------------------------------------------------------
  localparam logic [7:0] SYNC_LO = 8'hFF;
  localparam logic [7:0] SYNC_HI = 8'h81;
  localparam logic [15:0] SYNC_WORD = {SYNC_HI, SYNC_LO};
  localparam logic [15:0] MIN_SUM = 16'h8000;
  localparam logic [16:0] W_ID = 17'h00001;
  localparam logic [16:0] W_CNT = 17'h00002;
  localparam logic [16:0] W_FLG = 17'h00003;
  localparam logic [16:0] W_HCK = 17'h00004;
  localparam logic [16:0] W_DATA0 = 17'h00005;

  // ----------------------------------------------------------------
  // States
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    F_HUNT = 2'b00,
    F_HDR = 2'b01,
    F_DATA = 2'b10
  } frame_st_t;

  typedef enum logic [1:0] {
    H_IDLE = 2'b00,
    H_SEND = 2'b01,
    H_WAIT = 2'b10
  } host_st_t;

  // Negated sum; the most negative sum cannot be negated so it passes as is
  function automatic logic [15:0] chk_of(input logic [15:0] s);
    return (s == MIN_SUM) ? s : (~s + 16'h0001);
  endfunction

endpackage

// ### verilog/ser_link_if.sv
// Serial line between the host end and the device end.
// Assumes the host drives the line and holds it at the idle level outside characters.
`timescale 1ns/1ps
interface ser_link_if;
  logic h2d;
  modport host (output h2d);
  modport device (input h2d);
endinterface

// ### verilog/msg_framer.sv
// Host end: frames one message from header fields and streamed data words.
// Assumes the user holds the header inputs only for the I_START cycle.
`timescale 1ns/1ps
module msg_framer #(
  parameter int BIT_CYC = msg_frame_pkg::BIT_CYC_DEF
) (
  // Clock and reset
  input wire logic I_CLK,
  input wire logic I_ARST_N,
  // Message request
  input wire logic I_START,
  input wire logic [15:0] I_MSG_ID,
  input wire logic [15:0] I_COUNT,
  input wire logic [15:0] I_FLAGS,
  // Data words
  input wire logic [15:0] I_DATA,
  input wire logic I_DATA_VALID,
  output logic O_DATA_TAKEN,
  // Status
  output logic O_BUSY,
  output logic O_DONE,
  // Serial link
  ser_link_if.host LNK
);
  import msg_frame_pkg::*;

  localparam logic [CNT_W-1:0] BIT_M1 = CNT_W'(BIT_CYC - 1);

  // ----------------------------------------------------------------
  // Sequencing state
  // ----------------------------------------------------------------
  host_st_t st_q;
  logic tx_q;
  logic [8:0] sh_q;
  logic [3:0] bcnt_q;
  logic [CNT_W-1:0] baud_q;
  logic hi_q;
  logic [15:0] word_q;
  logic [16:0] widx_q;
  logic [15:0] id_q;
  logic [15:0] cnt_q;
  logic [15:0] flg_q;
  logic [15:0] dsum_q;

  // ----------------------------------------------------------------
  // Next word selection
  // ----------------------------------------------------------------
  logic [16:0] nidx;
  logic [16:0] cks_idx;
  logic [15:0] hsum;
  logic char_end;
  logic need_data;
  logic at_end;
  logic [15:0] nword;

  assign nidx = widx_q + 17'h00001;
  assign cks_idx = W_DATA0 + {1'b0, cnt_q};
  assign hsum = SYNC_WORD + id_q + cnt_q + flg_q;
  assign char_end = (st_q == H_SEND) && (baud_q == '0) && (bcnt_q == 4'h0);
  // No data part and no data checksum when the count is zero
  assign need_data = (nidx >= W_DATA0) && (nidx < cks_idx);
  assign at_end = (nidx > cks_idx) || ((nidx == cks_idx) && (cnt_q == 16'h0000));
  assign nword = (nidx == W_ID) ? id_q :
                 (nidx == W_CNT) ? cnt_q :
                 (nidx == W_FLG) ? flg_q :
                 (nidx == W_HCK) ? chk_of(hsum) :
                 chk_of(dsum_q);

  assign LNK.h2d = tx_q;

  // ----------------------------------------------------------------
  // Character transmitter and word sequencer
  // ----------------------------------------------------------------
  // Line only idles between characters while waiting for a data word
  always_ff @(posedge I_CLK or negedge I_ARST_N) begin
    if (!I_ARST_N) begin
      st_q <= H_IDLE;
      tx_q <= LINE_IDLE;
      sh_q <= 9'h000;
      bcnt_q <= 4'h0;
      baud_q <= '0;
      hi_q <= 1'b0;
      word_q <= 16'h0000;
      widx_q <= 17'h00000;
      id_q <= 16'h0000;
      cnt_q <= 16'h0000;
      flg_q <= 16'h0000;
      dsum_q <= 16'h0000;
      O_DATA_TAKEN <= 1'b0;
      O_BUSY <= 1'b0;
      O_DONE <= 1'b0;
    end else begin
      O_DATA_TAKEN <= 1'b0;
      O_DONE <= 1'b0;
      case (st_q)
        H_IDLE: begin
          if (I_START) begin
            id_q <= I_MSG_ID;
            cnt_q <= I_COUNT;
            flg_q <= I_FLAGS;
            dsum_q <= 16'h0000;
            widx_q <= 17'h00000;
            word_q <= SYNC_WORD;
            hi_q <= 1'b0;
            tx_q <= START_LVL;
            sh_q <= {LINE_IDLE, SYNC_LO};
            bcnt_q <= CHAR_BITS;
            baud_q <= BIT_M1;
            O_BUSY <= 1'b1;
            st_q <= H_SEND;
          end
        end
        H_SEND: begin
          if (baud_q != '0) begin
            baud_q <= baud_q - 1'b1;
          end else if (!char_end) begin
            tx_q <= sh_q[0];
            sh_q <= {1'b0, sh_q[8:1]};
            bcnt_q <= bcnt_q - 4'h1;
            baud_q <= BIT_M1;
          end else if (!hi_q) begin
            hi_q <= 1'b1;
            tx_q <= START_LVL;
            sh_q <= {LINE_IDLE, word_q[15:8]};
            bcnt_q <= CHAR_BITS;
            baud_q <= BIT_M1;
          end else if (at_end) begin
            O_BUSY <= 1'b0;
            O_DONE <= 1'b1;
            st_q <= H_IDLE;
          end else if (need_data) begin
            st_q <= H_WAIT;
          end else begin
            widx_q <= nidx;
            word_q <= nword;
            hi_q <= 1'b0;
            tx_q <= START_LVL;
            sh_q <= {LINE_IDLE, nword[7:0]};
            bcnt_q <= CHAR_BITS;
            baud_q <= BIT_M1;
          end
        end
        H_WAIT: begin
          if (I_DATA_VALID) begin
            O_DATA_TAKEN <= 1'b1;
            dsum_q <= dsum_q + I_DATA;
            widx_q <= nidx;
            word_q <= I_DATA;
            hi_q <= 1'b0;
            tx_q <= START_LVL;
            sh_q <= {LINE_IDLE, I_DATA[7:0]};
            bcnt_q <= CHAR_BITS;
            baud_q <= BIT_M1;
            st_q <= H_SEND;
          end
        end
        default: begin
          st_q <= H_IDLE;
        end
      endcase
    end
  end

endmodule

// ### tb/msg_link_monitor.sv
// Checker for the serial line between the framer and the deframer.
// Assumes one clock domain and sits beside the link in the bench.
`timescale 1ns/1ps
module msg_link_monitor #(
  parameter int BIT_CYC = 8
) (
  // Clock and reset
  input wire logic I_CLK,
  input wire logic I_ARST_N,
  // Line and framer side
  input wire logic h2d,
  input wire logic I_START,
  input wire logic O_BUSY,
  input wire logic O_DONE,
  input wire logic O_DATA_TAKEN,
  // Deframer side
  input wire logic O_WORD_VALID,
  input wire logic O_MSG_VALID,
  input wire logic O_HDR_ERR,
  input wire logic O_DATA_ERR
);
  // ----------------------------------------------------------------
  // Helpers and properties
  // ----------------------------------------------------------------
  default clocking cb @(posedge I_CLK);
  endclocking
  default disable iff (!I_ARST_N);

  logic [15:0] run_q;
  wire logic any_end = O_MSG_VALID | O_HDR_ERR | O_DATA_ERR;

  // Cycles since the line last changed; low runs must be whole bit periods
  always_ff @(posedge I_CLK or negedge I_ARST_N) begin
    if (!I_ARST_N) run_q <= 16'h0000;
    else run_q <= $changed(h2d) ? 16'h0001 : run_q + 16'h0001;
  end

  property p_low_run;
    $changed(h2d) && !$past(h2d) |-> (run_q % BIT_CYC) == 0;
  endproperty
  a_low_run: assert property (p_low_run) else $error("low run not whole bits");

  property p_idle;
    !O_BUSY |-> h2d;
  endproperty
  a_idle: assert property (p_idle) else $error("line not idle");

  property p_start;
    I_START && !O_BUSY |=> O_BUSY && !h2d;
  endproperty
  a_start: assert property (p_start) else $error("no start bit");

  // Probe the middle of the stop period, clear of the last data bit
  property p_done;
    O_DONE |-> $fell(O_BUSY) && h2d && $past(h2d, BIT_CYC / 2);
  endproperty
  a_done: assert property (p_done) else $error("done off stop");

  property p_taken;
    O_DATA_TAKEN |-> (O_BUSY && !h2d) ##1 !O_DATA_TAKEN;
  endproperty
  a_taken: assert property (p_taken) else $error("taken misplaced");

  property p_one_end;
    $onehot0({O_MSG_VALID, O_HDR_ERR, O_DATA_ERR});
  endproperty
  a_one_end: assert property (p_one_end) else $error("two outcomes");

  property p_end_quiet;
    any_end |=> !any_end [*8];
  endproperty
  a_end_quiet: assert property (p_end_quiet) else $error("outcome repeats");

  property p_word_first;
    O_WORD_VALID |=> !any_end [*8];
  endproperty
  a_word_first: assert property (p_word_first) else $error("end too soon");

  property p_end_stop;
    any_end |-> $past(h2d, 3);
  endproperty
  a_end_stop: assert property (p_end_stop) else $error("end off stop");
endmodule

// ### tb/test_binary_message_word_framer.sv
// Bench joining framer and deframer, plus a second deframer fed raw bytes.
// Assumes BIT_CYC of 8 on every end and a 40 MHz clock.
`timescale 1ns/1ps
module test_binary_message_word_framer;
  // ----------------------------------------------------------------
  // Signals and instances
  // ----------------------------------------------------------------
  localparam int BC = 8;
  logic clk = 1'b0;
  logic arst_n = 1'b0;
  logic start = 1'b0;
  logic dval = 1'b0;
  logic [15:0] id_in = 16'h0000;
  logic [15:0] cnt_in = 16'h0000;
  logic [15:0] flg_in = 16'h0000;
  logic [15:0] dat_in = 16'h0000;
  wire logic taken, busy, done, wval, mval, herr, derr, mval_b, herr_b, derr_b;
  wire logic [15:0] mid, mcnt, mflg, word;
  logic [15:0] dat [4];
  logic [15:0] got_w [$];
  logic [2:0] outc;
  logic [2:0] outc_b;
  int failures = 0;
  int checked = 0;
  ser_link_if lnk ();
  ser_link_if lnk_b ();

  always #12.5 clk = ~clk;

  msg_framer #(.BIT_CYC(BC)) msg_framer_i (.I_CLK(clk), .I_ARST_N(arst_n),
    .I_START(start), .I_MSG_ID(id_in), .I_COUNT(cnt_in), .I_FLAGS(flg_in),
    .I_DATA(dat_in), .I_DATA_VALID(dval), .O_DATA_TAKEN(taken), .O_BUSY(busy),
    .O_DONE(done), .LNK(lnk.host));
  msg_deframer #(.BIT_CYC(BC)) msg_deframer_i (.I_CLK(clk), .I_ARST_N(arst_n),
    .LNK(lnk.device), .O_MSG_ID(mid), .O_COUNT(mcnt), .O_FLAGS(mflg), .O_WORD(word),
    .O_WORD_VALID(wval), .O_MSG_VALID(mval), .O_HDR_ERR(herr), .O_DATA_ERR(derr));
  // Second deframer sees bytes the bench breaks on purpose
  msg_deframer #(.BIT_CYC(BC)) msg_deframer_b_i (.I_CLK(clk), .I_ARST_N(arst_n),
    .LNK(lnk_b.device), .O_MSG_ID(), .O_COUNT(), .O_FLAGS(), .O_WORD(),
    .O_WORD_VALID(), .O_MSG_VALID(mval_b), .O_HDR_ERR(herr_b), .O_DATA_ERR(derr_b));
  msg_link_monitor #(.BIT_CYC(BC)) msg_link_monitor_i (.I_CLK(clk), .I_ARST_N(arst_n),
    .h2d(lnk.h2d), .I_START(start), .O_BUSY(busy), .O_DONE(done),
    .O_DATA_TAKEN(taken), .O_WORD_VALID(wval), .O_MSG_VALID(mval),
    .O_HDR_ERR(herr), .O_DATA_ERR(derr));

  // Collect data words and the last outcome of each deframer
  always @(posedge clk) begin
    if (wval) got_w.push_back(word);
    if (mval | herr | derr) outc <= {mval, herr, derr};
    if (mval_b | herr_b | derr_b) outc_b <= {mval_b, herr_b, derr_b};
  end

  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task automatic chk_w(input logic [15:0] got, input logic [15:0] exp);
    checked++;
    if (got !== exp) begin
      failures++;
      $display("unexpected word at %0t: got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic chk_end(input logic [2:0] got, input logic [2:0] exp);
    checked++;
    if (got !== exp) begin
      failures++;
      $display("unexpected outcome at %0t: got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic conclude;
    $display("checked %0d failures %0d", checked, failures);
    if (failures == 0 && checked > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  // Negated sum; the most negative sum cannot be negated
  function automatic logic [15:0] neg_sum(input logic [15:0] s);
    return (s == 16'h8000) ? s : 16'h0000 - s;
  endfunction

  // Bounded wait; a missing outcome then shows as a mismatch
  task automatic wait_end(input logic b);
    int n;
    n = 0;
    while (((b ? outc_b : outc) == 3'h0) && n < 3000) begin
      @(negedge clk);
      n++;
    end
  endtask

  // Start is held two cycles with the ID altered: the second must be refused
  task automatic send_msg(input logic [15:0] id, cnt, flg);
    int n;
    outc = 3'h0;
    got_w.delete();
    id_in = id;
    cnt_in = cnt;
    flg_in = flg;
    start = 1'b1;
    @(negedge clk);
    id_in = ~id;
    @(negedge clk);
    start = 1'b0;
    for (int i = 0; i < cnt; i++) begin
      repeat (i * 5) @(negedge clk);
      dat_in = dat[i];
      dval = 1'b1;
      n = 0;
      while (taken !== 1'b1 && n < 3000) begin
        @(negedge clk);
        n++;
      end
      dval = 1'b0;
    end
    wait_end(1'b0);
    chk_end(outc, 3'h4);
    chk_w(mid, id);
    chk_w(mcnt, cnt);
    chk_w(mflg, flg);
    chk_w(16'(got_w.size()), cnt);
    for (int i = 0; i < cnt; i++) chk_w(got_w[i], dat[i]);
  endtask

  // One character: start, eight bits low first, stop
  task automatic raw_byte(input logic [7:0] b);
    logic [9:0] f;
    f = {1'b1, b, 1'b0};
    for (int i = 0; i < 10; i++) begin
      lnk_b.h2d = f[i];
      repeat (BC) @(negedge clk);
    end
  endtask

  // Whole message on the second line; hx and dx spoil the checksums
  task automatic raw_msg(input logic [15:0] id, cnt, flg, hx, dx);
    logic [15:0] w [$];
    logic [15:0] s;
    outc_b = 3'h0;
    w = '{16'h81FF, id, cnt, flg};
    s = 16'h81FF + id + cnt + flg;
    w.push_back(neg_sum(s) ^ hx);
    s = 16'h0000;
    for (int i = 0; i < cnt; i++) begin
      w.push_back(dat[i]);
      s += dat[i];
    end
    if (cnt != 0) w.push_back(neg_sum(s) ^ dx);
    foreach (w[i]) begin
      raw_byte(w[i][7:0]);
      raw_byte(w[i][15:8]);
    end
    wait_end(1'b1);
  endtask

  // Decode one character off the joined line at mid bit
  task automatic grab(output logic [7:0] b);
    @(negedge lnk.h2d);
    repeat (BC + BC / 2) @(negedge clk);
    for (int i = 0; i < 8; i++) begin
      b[i] = lnk.h2d;
      repeat (BC) @(negedge clk);
    end
  endtask

  // ----------------------------------------------------------------
  // Sequence and watchdog
  // ----------------------------------------------------------------
  initial begin
    logic [7:0] b [4];
    lnk_b.h2d = 1'b1;
    repeat (2) @(negedge clk);
    arst_n = 1'b1;
    repeat (3) @(negedge clk);
    fork
      send_msg(16'h03E8, 16'h0000, 16'h0021);
      for (int k = 0; k < 4; k++) grab(b[k]);
    join
    chk_w({b[1], b[0]}, 16'h81FF);
    chk_w({b[3], b[2]}, 16'h03E8);
    send_msg(16'hFE01, 16'h0000, 16'h0000);
    dat = '{16'h1234, 16'hFFFF, 16'h0080, 16'hA55A};
    send_msg(16'h0101, 16'h0004, 16'h0000);
    raw_msg(16'h0022, 16'h0000, 16'h0000, 16'h0001, 16'h0000);
    chk_end(outc_b, 3'h2);
    raw_byte(8'h81);
    raw_byte(8'hFF);
    raw_msg(16'h0023, 16'h0000, 16'h0000, 16'h0000, 16'h0000);
    chk_end(outc_b, 3'h4);
    raw_msg(16'h0024, 16'h0002, 16'h0000, 16'h0000, 16'h0100);
    chk_end(outc_b, 3'h1);
    raw_msg(16'h0025, 16'h0001, 16'h0000, 16'h0000, 16'h0000);
    chk_end(outc_b, 3'h4);
    conclude();
  end

  // A hang counts as a mismatch
  initial begin
    repeat (40000) @(posedge clk);
    failures++;
    conclude();
  end
endmodule
